/* rtl/window_ptr_pkg.sv */
// constants for the sram window pointer wrap block
package window_ptr_pkg;
   localparam int addr_w = 16; // pointer width
   localparam int mem_depth = 24576; // bytes of sram
   localparam logic [15:0] mem_last = 16'h5fff; // last implemented byte
   localparam logic [15:0] mem_first = 16'h0000; // first byte
   localparam logic [15:0] rx_start_reset = 16'h5340; // rx area start after reset
   localparam logic [15:0] ua_start_reset = 16'h6000; // user area parked off memory
   localparam logic [15:0] ua_end_reset = 16'h6001; // user area parked off memory
   localparam logic [15:0] ptr_reset = 16'h0000; // pointers after reset
   localparam logic [7:0] data_reset = 8'h00; // data windows after reset
   localparam int bit_lsb = 0; // position of alignment bit
endpackage

/* rtl/sram_window_pointer_wrap.sv */
// two indirect sram data windows with auto-advancing wrapping pointers
`timescale 1ns/1ps
module sram_window_pointer_wrap
   import window_ptr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_rd, // read the rx data window
   input wire logic rx_wr, // write the rx data window
   input wire logic ua_rd, // read the user area data window
   input wire logic ua_wr, // write the user area data window
   input wire logic [7:0] wr_data, // byte written through a window
   input wire logic ptr_load, // load pointer or boundary
   input wire logic [2:0] ptr_sel, // 0 rx rd,1 rx wr,2 ua rd,3 ua wr,4 rx st,5 ua st,6 ua end
   input wire logic [15:0] ptr_data, // value for ptr_load
   output logic [7:0] rx_data_window, // byte read through rx window
   output logic [7:0] user_area_data_window, // byte read through user window
   output logic [15:0] rx_read_pointer,
   output logic [15:0] rx_write_pointer,
   output logic [15:0] user_area_read_pointer,
   output logic [15:0] user_area_write_pointer,
   output logic [15:0] rx_buffer_start,
   output logic [15:0] user_area_start,
   output logic [15:0] user_area_end
);
   ////////////////////////////////////////////////////////////////////////////////
   // functions
   // rx step: end of memory goes back to rx start
   function automatic logic [15:0] rx_step(input logic [15:0] p, input logic [15:0] st);
      if (p == mem_last) begin
         rx_step = st;
      end else begin
         rx_step = p + 16'h0001;
      end
   endfunction
   // user step: end match first, then end of memory, never rx start
   function automatic logic [15:0] ua_step(input logic [15:0] p, input logic [15:0] st,
                                          input logic [15:0] nd);
      if (p == nd) begin
         ua_step = st;
      end else if (p == mem_last) begin
         ua_step = mem_first;
      end else begin
         ua_step = p + 16'h0001;
      end
   endfunction
   // sram index of a pointer; pointers past the top alias back into memory
   function automatic logic [14:0] alias_index(input logic [15:0] p);
      logic [15:0] wrapped; // pointer folded into the implemented range
      wrapped = p % 16'(mem_depth);
      alias_index = wrapped[14:0];
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] mem [0:mem_depth-1]; // sram bytes, one flip-flop byte per address
   logic [15:0] next_rx_rd; // rx read pointer after this cycle
   logic [15:0] next_rx_wr; // rx write pointer after this cycle
   logic [15:0] next_ua_rd; // user area read pointer after this cycle
   logic [15:0] next_ua_wr; // user area write pointer after this cycle
   logic [15:0] next_rx_st; // rx buffer start after this cycle
   logic [15:0] next_ua_st; // user area start after this cycle
   logic [15:0] next_ua_nd; // user area end after this cycle
   logic [7:0] next_rx_q; // rx window read byte after this cycle
   logic [7:0] next_ua_q; // user window read byte after this cycle
   logic mem_we; // a window write lands in sram this cycle
   logic [14:0] mem_idx; // sram byte that the write lands in
   logic [7:0] mem_byte; // byte stored by the write
   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic for pointers, boundaries and read data
   always_comb begin
      next_rx_rd = rx_read_pointer;
      next_rx_wr = rx_write_pointer;
      next_ua_rd = user_area_read_pointer;
      next_ua_wr = user_area_write_pointer;
      next_rx_st = rx_buffer_start;
      next_ua_st = user_area_start;
      next_ua_nd = user_area_end;
      next_rx_q = rx_data_window;
      next_ua_q = user_area_data_window;
      // window reads present the byte at the read pointer
      if (rx_rd) begin
         next_rx_q = mem[alias_index(rx_read_pointer)];
         next_rx_rd = rx_step(rx_read_pointer, rx_buffer_start);
      end
      if (rx_wr) begin
         next_rx_wr = rx_step(rx_write_pointer, rx_buffer_start);
      end
      if (ua_rd) begin
         next_ua_q = mem[alias_index(user_area_read_pointer)];
         next_ua_rd = ua_step(user_area_read_pointer, user_area_start, user_area_end);
      end
      if (ua_wr) begin
         next_ua_wr = ua_step(user_area_write_pointer, user_area_start, user_area_end);
      end
      // host loads override the step of the same pointer
      if (ptr_load) begin
         case (ptr_sel)
            3'h0: next_rx_rd = ptr_data;
            3'h1: next_rx_wr = ptr_data;
            3'h2: next_ua_rd = ptr_data;
            3'h3: next_ua_wr = ptr_data;
            3'h4: next_rx_st = {ptr_data[15:1], 1'h0};
            3'h5: next_ua_st = {ptr_data[15:1], 1'h0};
            3'h6: next_ua_nd = {ptr_data[15:1], 1'h1};
            default: next_rx_st = rx_buffer_start;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_read_pointer <= ptr_reset;
         rx_write_pointer <= ptr_reset;
         user_area_read_pointer <= ptr_reset;
         user_area_write_pointer <= ptr_reset;
         rx_buffer_start <= rx_start_reset;
         user_area_start <= ua_start_reset;
         user_area_end <= ua_end_reset;
         rx_data_window <= data_reset;
         user_area_data_window <= data_reset;
      end else begin
         rx_read_pointer <= next_rx_rd;
         rx_write_pointer <= next_rx_wr;
         user_area_read_pointer <= next_ua_rd;
         user_area_write_pointer <= next_ua_wr;
         rx_buffer_start <= next_rx_st;
         user_area_start <= next_ua_st;
         user_area_end <= next_ua_nd;
         rx_data_window <= next_rx_q;
         user_area_data_window <= next_ua_q;
      end
   end
   // sram write select: user window first, rx window last so that rx wins a clash
   always_comb begin
      mem_we = 1'h0;
      mem_idx = 15'h0000;
      mem_byte = wr_data;
      // writes above the top of memory store nothing
      if (ua_wr && user_area_write_pointer <= mem_last) begin
         mem_we = 1'h1;
         mem_idx = user_area_write_pointer[14:0];
      end
      if (rx_wr && rx_write_pointer <= mem_last) begin
         mem_we = 1'h1;
         mem_idx = rx_write_pointer[14:0];
      end
   end
   // sram byte register
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_idx] <= mem_byte;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   property p_rx_wrap;
      @(posedge clk) disable iff (rst)
      (rx_rd && !ptr_load && rx_read_pointer == mem_last)
         |=> rx_read_pointer == $past(rx_buffer_start);
   endproperty
   a_rx_wrap: assert property (p_rx_wrap) else $error("rx pointer wrap wrong");
   property p_rx_inc;
      @(posedge clk) disable iff (rst)
      (rx_wr && !ptr_load && rx_write_pointer != mem_last)
         |=> rx_write_pointer == $past(rx_write_pointer) + 16'h0001;
   endproperty
   a_rx_inc: assert property (p_rx_inc) else $error("rx write pointer step wrong");
   property p_ua_end;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_read_pointer == user_area_end)
         |=> user_area_read_pointer == $past(user_area_start);
   endproperty
   a_ua_end: assert property (p_ua_end) else $error("user end wrap wrong");
   property p_ua_mem;
      @(posedge clk) disable iff (rst)
      (ua_wr && !ptr_load && user_area_write_pointer == mem_last
         && user_area_end != mem_last) |=> user_area_write_pointer == mem_first;
   endproperty
   a_ua_mem: assert property (p_ua_mem) else $error("user memory wrap wrong");
   property p_ua_inc;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_read_pointer != user_area_end
         && user_area_read_pointer != mem_last)
         |=> user_area_read_pointer == $past(user_area_read_pointer) + 16'h0001;
   endproperty
   a_ua_inc: assert property (p_ua_inc) else $error("user step wrong");
   property p_rd_keeps_wr;
      @(posedge clk) disable iff (rst)
      (rx_rd && !rx_wr && !ptr_load) |=> $stable(rx_write_pointer);
   endproperty
   a_rd_keeps_wr: assert property (p_rd_keeps_wr) else $error("read moved write ptr");
   property p_ua_align;
      @(posedge clk) disable iff (rst)
      1'h1 |-> !user_area_start[bit_lsb] && user_area_end[bit_lsb];
   endproperty
   a_ua_align: assert property (p_ua_align) else $error("user bounds misaligned");
   property p_rx_align;
      @(posedge clk) disable iff (rst)
      1'h1 |-> !rx_buffer_start[bit_lsb];
   endproperty
   a_rx_align: assert property (p_rx_align) else $error("rx start odd");
   property p_ua_no_rx_wrap;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_read_pointer == rx_buffer_start - 16'h0001
         && user_area_read_pointer != user_area_end
         && user_area_read_pointer != mem_last)
         |=> user_area_read_pointer == rx_buffer_start;
   endproperty
   a_ua_no_rx_wrap: assert property (p_ua_no_rx_wrap) else $error("user wrapped at rx");
   // rx read pointer steps by one below the top
   property p_rx_rd_inc;
      @(posedge clk) disable iff (rst)
      (rx_rd && !ptr_load && rx_read_pointer != mem_last)
         |=> rx_read_pointer == $past(rx_read_pointer) + 16'h0001;
   endproperty
   a_rx_rd_inc: assert property (p_rx_rd_inc) else $error("rx read step wrong");
   // rx write pointer at the top goes back to the rx start
   property p_rx_wr_wrap;
      @(posedge clk) disable iff (rst)
      (rx_wr && !ptr_load && rx_write_pointer == mem_last)
         |=> rx_write_pointer == $past(rx_buffer_start);
   endproperty
   a_rx_wr_wrap: assert property (p_rx_wr_wrap) else $error("rx write wrap wrong");
   // user write pointer at the end goes back to the user start
   property p_ua_wr_end;
      @(posedge clk) disable iff (rst)
      (ua_wr && !ptr_load && user_area_write_pointer == user_area_end)
         |=> user_area_write_pointer == $past(user_area_start);
   endproperty
   a_ua_wr_end: assert property (p_ua_wr_end) else $error("user write end wrong");
   // user read pointer at the top of memory goes to the bottom
   property p_ua_rd_mem;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_read_pointer == mem_last
         && user_area_end != mem_last) |=> user_area_read_pointer == mem_first;
   endproperty
   a_ua_rd_mem: assert property (p_ua_rd_mem) else $error("user read top wrong");
   // user write pointer steps by one away from both boundaries
   property p_ua_wr_inc;
      @(posedge clk) disable iff (rst)
      (ua_wr && !ptr_load && user_area_write_pointer != user_area_end
         && user_area_write_pointer != mem_last)
         |=> user_area_write_pointer == $past(user_area_write_pointer) + 16'h0001;
   endproperty
   a_ua_wr_inc: assert property (p_ua_wr_inc) else $error("user write step wrong");
   // an end at the top of memory still sends the pointer to the user start
   property p_ua_top_end;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_read_pointer == mem_last
         && user_area_end == mem_last) |=> user_area_read_pointer == $past(user_area_start);
   endproperty
   a_ua_top_end: assert property (p_ua_top_end) else $error("end at top wrong");
   // start above end: the pointer jumps over the exclusion zone
   property p_ua_gap;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ptr_load && user_area_start > user_area_end
         && user_area_read_pointer == user_area_end)
         |=> user_area_read_pointer == $past(user_area_start);
   endproperty
   a_ua_gap: assert property (p_ua_gap) else $error("gap not skipped");
   // a user read leaves the user write pointer alone
   property p_ua_rd_keeps;
      @(posedge clk) disable iff (rst)
      (ua_rd && !ua_wr && !ptr_load) |=> $stable(user_area_write_pointer);
   endproperty
   a_ua_rd_keeps: assert property (p_ua_rd_keeps) else $error("user read moved write");
   // an rx write leaves the rx read pointer alone
   property p_rx_wr_keeps;
      @(posedge clk) disable iff (rst)
      (rx_wr && !rx_rd && !ptr_load) |=> $stable(rx_read_pointer);
   endproperty
   a_rx_wr_keeps: assert property (p_rx_wr_keeps) else $error("rx write moved read");
   // no access and no load leaves every pointer where it is
   property p_idle_hold;
      @(posedge clk) disable iff (rst)
      (!rx_rd && !rx_wr && !ua_rd && !ua_wr && !ptr_load)
         |=> $stable(rx_read_pointer) && $stable(rx_write_pointer)
            && $stable(user_area_read_pointer) && $stable(user_area_write_pointer);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle pointer moved");
   // rx read byte stands until the next rx read
   property p_rx_q_hold;
      @(posedge clk) disable iff (rst)
      !rx_rd |=> $stable(rx_data_window);
   endproperty
   a_rx_q_hold: assert property (p_rx_q_hold) else $error("rx data changed");
   // user read byte stands until the next user read
   property p_ua_q_hold;
      @(posedge clk) disable iff (rst)
      !ua_rd |=> $stable(user_area_data_window);
   endproperty
   a_ua_q_hold: assert property (p_ua_q_hold) else $error("user data changed");
   // a loaded end keeps the host's upper bits and an odd low bit
   property p_ua_end_load;
      @(posedge clk) disable iff (rst)
      (ptr_load && ptr_sel == 3'h6) |=> user_area_end == {$past(ptr_data[15:1]), 1'h1};
   endproperty
   a_ua_end_load: assert property (p_ua_end_load) else $error("user end load wrong");
   // a loaded start keeps the host's upper bits and an even low bit
   property p_ua_st_load;
      @(posedge clk) disable iff (rst)
      (ptr_load && ptr_sel == 3'h5) |=> user_area_start == {$past(ptr_data[15:1]), 1'h0};
   endproperty
   a_ua_st_load: assert property (p_ua_st_load) else $error("user start load wrong");
   c_rx_wrap: cover property (@(posedge clk) rx_rd && rx_read_pointer == mem_last);
   c_ua_end: cover property (@(posedge clk) ua_rd && user_area_read_pointer == user_area_end);
   c_ua_mem: cover property (@(posedge clk) ua_wr && user_area_write_pointer == mem_last);
   c_back2back: cover property (@(posedge clk) ua_rd ##1 ua_rd);
endmodule // sram_window_pointer_wrap

/* verif/host_model.sv */
// host microcontroller model driving the window strobes and pointer loads
`timescale 1ns/1ps
module host_model
   import window_ptr_pkg::*;
(
   input wire logic clk,
   output logic rx_rd,
   output logic rx_wr,
   output logic ua_rd,
   output logic ua_wr,
   output logic [7:0] wr_data,
   output logic ptr_load,
   output logic [2:0] ptr_sel,
   output logic [15:0] ptr_data
);
   // idle host: no strobes, no target selected
   initial begin
      {ua_wr, ua_rd, rx_wr, rx_rd, ptr_load} = 5'h00;
      wr_data = 8'h00;
      ptr_sel = 3'h7;
      ptr_data = 16'h0000;
   end
   // one load cycle; released data shows the inverse, not the old value
   task automatic put(input logic [2:0] sel, input logic [15:0] val);
      @(negedge clk);
      ptr_load = 1'h1;
      ptr_sel = sel;
      ptr_data = val;
      @(negedge clk);
      ptr_load = 1'h0;
      ptr_sel = 3'h7;
      ptr_data = ~val;
   endtask
   // one access with a load in the same cycle
   task automatic load_hit(input logic [3:0] kind, input logic [7:0] b,
                           input logic [2:0] sel, input logic [15:0] val);
      @(negedge clk);
      {ua_wr, ua_rd, rx_wr, rx_rd} = kind;
      wr_data = b;
      ptr_load = 1'h1;
      ptr_sel = sel;
      ptr_data = val;
      @(negedge clk);
      {ua_wr, ua_rd, rx_wr, rx_rd} = 4'h0;
      ptr_load = 1'h0;
      ptr_sel = 3'h7;
      ptr_data = ~val;
      wr_data = ~b;
   endtask
   // n back-to-back accesses, kind = {ua_wr, ua_rd, rx_wr, rx_rd}
   task automatic hit(input logic [3:0] kind, input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         {ua_wr, ua_rd, rx_wr, rx_rd} = kind;
         wr_data = b + 8'(i);
      end
      @(negedge clk);
      {ua_wr, ua_rd, rx_wr, rx_rd} = 4'h0;
      wr_data = ~b;
   endtask
   // parking the user area off memory disables it
   task automatic park_user_area();
      put(3'h5, 16'h6000);
      put(3'h6, 16'h6001);
   endtask
endmodule // host_model

/* verif/test_sram_window_pointer_wrap.sv */
// self-checking bench for the window pointer wrap block
`timescale 1ns/1ps
module test_sram_window_pointer_wrap;
   import window_ptr_pkg::*;
   logic clk, rst, rx_rd, rx_wr, ua_rd, ua_wr, ptr_load;
   logic [7:0] wr_data, rxd, uad;
   logic [2:0] ptr_sel;
   logic [15:0] ptr_data, rrp, rwp, urp, uwp, rxs, uas, uae;
   int failures = 0;
   int compares = 0;
   sram_window_pointer_wrap dut_u (.clk(clk), .rst(rst), .rx_rd(rx_rd), .rx_wr(rx_wr),
      .ua_rd(ua_rd), .ua_wr(ua_wr), .wr_data(wr_data), .ptr_load(ptr_load),
      .ptr_sel(ptr_sel), .ptr_data(ptr_data), .rx_data_window(rxd),
      .user_area_data_window(uad), .rx_read_pointer(rrp), .rx_write_pointer(rwp),
      .user_area_read_pointer(urp), .user_area_write_pointer(uwp),
      .rx_buffer_start(rxs), .user_area_start(uas), .user_area_end(uae));
   host_model host_u (.clk(clk), .rx_rd(rx_rd), .rx_wr(rx_wr), .ua_rd(ua_rd), .ua_wr(ua_wr),
      .wr_data(wr_data), .ptr_load(ptr_load), .ptr_sel(ptr_sel), .ptr_data(ptr_data));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // rx write runs off the top into the rx start, reads follow it
   task automatic rx_wrap();
      host_u.put(3'h4, 16'h5341);
      check("rx start", rxs, 16'h5340);
      host_u.put(3'h1, 16'h5ffe);
      host_u.hit(4'h2, 8'ha1, 2);
      check("rx wr ptr", rwp, 16'h5340);
      check("rx rd ptr idle", rrp, 16'h0000);
      host_u.put(3'h0, 16'h5ffe);
      host_u.hit(4'h1, 8'h00, 1);
      check("rx read a", {8'h00, rxd}, 16'h00a1);
      host_u.hit(4'h1, 8'h00, 1);
      check("rx read b", {8'h00, rxd}, 16'h00a2);
      check("rx rd ptr", rrp, 16'h5340);
   endtask
   // bounds forced to even start and odd end, pointer wraps at end
   task automatic ua_bounds();
      host_u.put(3'h5, 16'h0101);
      check("ua start", uas, 16'h0100);
      host_u.put(3'h6, 16'h0102);
      check("ua end", uae, 16'h0103);
      host_u.put(3'h3, 16'h0102);
      host_u.hit(4'h8, 8'hb5, 2);
      check("ua wr ptr", uwp, 16'h0100);
      check("ua rd ptr idle", urp, 16'h0000);
      host_u.put(3'h2, 16'h0102);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua read a", {8'h00, uad}, 16'h00b5);
      check("ua rd ptr step", urp, 16'h0103);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua read b", {8'h00, uad}, 16'h00b6);
      check("ua rd ptr wrap", urp, 16'h0100);
   endtask
   // top of memory, end at the top, and an exclusion zone
   task automatic ua_top_and_gap();
      host_u.put(3'h2, 16'h5fff);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua top", urp, 16'h0000);
      host_u.put(3'h6, 16'h5fff);
      host_u.put(3'h2, 16'h5fff);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua end top", urp, 16'h0100);
      host_u.put(3'h5, 16'h0200);
      host_u.put(3'h6, 16'h0100);
      host_u.put(3'h2, 16'h0101);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua gap", urp, 16'h0200);
   endtask
   // disabled user area runs through the rx start to the top
   task automatic ua_full();
      host_u.park_user_area();
      host_u.put(3'h2, 16'h533f);
      host_u.hit(4'h4, 8'h00, 2);
      check("ua past rx start", urp, 16'h5341);
      host_u.put(3'h3, 16'h5fff);
      host_u.hit(4'h8, 8'h11, 1);
      check("ua disabled wrap", uwp, 16'h0000);
   endtask
   // bounds and pointers loaded while a window is busy
   task automatic busy_load();
      host_u.put(3'h1, 16'h5400);
      host_u.load_hit(4'h2, 8'h5a, 3'h6, 16'h0300);
      check("ua end busy", uae, 16'h0301);
      check("rx wr busy", rwp, 16'h5401);
      host_u.put(3'h2, 16'h0301);
      host_u.put(3'h5, 16'h0300);
      host_u.hit(4'h4, 8'h00, 1);
      check("ua next step", urp, 16'h0300);
      host_u.load_hit(4'h4, 8'h00, 3'h2, 16'h0200);
      check("ua load wins", urp, 16'h0200);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // watchdog for a hung run
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial begin
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      check("rx start rst", rxs, 16'h5340);
      check("ua start rst", uas, 16'h6000);
      check("ua end rst", uae, 16'h6001);
      rx_wrap();
      ua_bounds();
      ua_top_and_gap();
      ua_full();
      busy_load();
      stop_test();
   end
endmodule // test_sram_window_pointer_wrap
